/* verilog/smbus_select_slave_port.sv */
// Serial management slave port with port-select gating and register file
// Notes on behaviour
// - Select high enables port and register access
// - Select low: ignore traffic, never drive data
// - Port stays active in standby
// - Answer only slave address 1010110
// - Change data only while clock low
// - Data falling, clock high starts message
// - Data rising, clock high ends message
// - Idle after free time or high limit
// - Bus free time at least 4.7 us
// - Clock low past timeout aborts transaction
// - Acknowledge matching address byte low
// - Register address byte acknowledged low
// - Write data stored and acknowledged
// - Return addressed register, MSB first
module smbus_select_slave_port
  import smbus_port_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  // Port select and standby
  input  wire logic                      port_select,
  input  wire logic                      standby,
  // Bus clock line (input only for a slave)
  input  wire logic                      bus_clock_line,
  // Data line, open drain
  input  wire logic                      data_in,
  output logic                           data_out,
  output logic                           data_oe,
  // Status
  output logic                           bus_idle,
  output logic                           timeout_abort,
  // Register contents towards the datapath
  output smbus_port_pkg::reg_write_t     reg_write,
  output logic [255:0][7:0]              reg_image
);

  line_events_t ev;

  smbus_line_filter u_filter (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clock_in (bus_clock_line),
    .data_in  (data_in),
    .events   (ev)
  );

  typedef struct packed {
    logic [1:0]       sel_sync;
    phase_t           phase;
    logic [3:0]       bit_cnt;
    logic [7:0]       shreg;
    logic [1:0]       byte_idx;
    logic             read_dir;
    logic             ack_good;
    logic [7:0]       reg_addr;
    logic             pull_low;
    logic             idle;
    logic             stop_seen;
    logic [CNT_W-1:0] high_cnt;
    logic [CNT_W-1:0] low_cnt;
    logic             abort;
    reg_write_t       wr;
  } port_state_t;

  port_state_t cur;
  port_state_t next_cur;
  logic [7:0]  regs [0:255];
  logic        selected;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // Standby input is deliberately unused by the port logic
  assign selected = cur.sel_sync[1];

  always_comb
  begin
    next_cur = cur;
    next_cur.sel_sync = {cur.sel_sync[0], port_select};
    next_cur.wr.strobe = 1'b0;
    next_cur.abort = 1'b0;

    // Idle timing counters on the filtered levels
    if (ev.bus_clock_line && ev.data)
      next_cur.high_cnt = sat_inc(cur.high_cnt);
    else
      next_cur.high_cnt = '0;
    if (!ev.bus_clock_line)
      next_cur.low_cnt = sat_inc(cur.low_cnt);
    else
      next_cur.low_cnt = '0;
    if (ev.stop)
      next_cur.stop_seen = 1'b1;
    if ((cur.stop_seen && cur.high_cnt >= CNT_W'(FREE_CYCLES)) ||
        cur.high_cnt >= CNT_W'(HIGH_CYCLES))
    begin
      next_cur.idle = 1'b1;
      next_cur.stop_seen = 1'b0;
    end
    if (!ev.bus_clock_line || !ev.data)
      next_cur.idle = 1'b0;

    if (!selected)
    begin
      // Deselected: traffic is not decoded at all
      next_cur.phase = ST_IDLE;
      next_cur.pull_low = 1'b0;
    end
    else if (ev.start)
    begin
      next_cur.phase = ST_ADDR;
      next_cur.bit_cnt = '0;
      next_cur.pull_low = 1'b0;
      next_cur.byte_idx = '0;
    end
    else if (ev.stop)
    begin
      next_cur.phase = ST_IDLE;
      next_cur.pull_low = 1'b0;
    end
    else if (cur.low_cnt >= CNT_W'(LOW_CYCLES) && cur.phase != ST_IDLE)
    begin
      next_cur.phase = ST_IDLE;
      next_cur.pull_low = 1'b0;
      next_cur.abort = 1'b1;
    end
    else
    begin
      unique case (cur.phase)
        ST_IDLE, ST_IGNORE:
        begin
          next_cur.pull_low = 1'b0;
        end
        ST_ADDR, ST_RXBYTE:
        begin
          if (ev.clk_rise)
          begin
            next_cur.shreg = {cur.shreg[6:0], ev.data};
            next_cur.bit_cnt = cur.bit_cnt + 1'b1;
          end
          // Acknowledge driven after the falling edge of the eighth bit
          if (ev.clk_fall && cur.bit_cnt == ACK_SLOT)
          begin
            next_cur.bit_cnt = '0;
            if (cur.phase == ST_ADDR)
            begin
              if (cur.shreg[7:1] == SLAVE_ADDR)
              begin
                next_cur.read_dir = cur.shreg[0];
                next_cur.pull_low = 1'b1;
                next_cur.phase = ST_ACK;
              end
              else
                next_cur.phase = ST_IGNORE;
            end
            else
            begin
              if (cur.byte_idx == 2'd1)
                next_cur.reg_addr = cur.shreg;
              else
              begin
                next_cur.wr.strobe = 1'b1;
                next_cur.wr.addr = cur.reg_addr;
                next_cur.wr.data = cur.shreg;
                next_cur.reg_addr = cur.reg_addr + 1'b1;
              end
              next_cur.pull_low = 1'b1;
              next_cur.phase = ST_ACK;
            end
          end
        end
        ST_ACK:
        begin
          // After the ninth clock's falling edge: release, or drive the first bit when reading
          if (ev.clk_fall)
          begin
            next_cur.byte_idx = (cur.byte_idx == 2'd3) ? 2'd2 : cur.byte_idx + 1'b1;
            if (cur.read_dir)
            begin
              next_cur.shreg = regs[cur.reg_addr];
              next_cur.pull_low = ~regs[cur.reg_addr][7];
              next_cur.phase = ST_TXBYTE;
            end
            else
            begin
              next_cur.pull_low = 1'b0;
              next_cur.phase = ST_RXBYTE;
            end
          end
        end
        ST_TXBYTE:
        begin
          if (ev.clk_fall)
          begin
            next_cur.bit_cnt = cur.bit_cnt + 1'b1;
            if (cur.bit_cnt == 4'd7)
            begin
              next_cur.pull_low = 1'b0;
              next_cur.phase = ST_TXACK;
              next_cur.bit_cnt = '0;
            end
            else
            begin
              next_cur.shreg = {cur.shreg[6:0], 1'b0};
              next_cur.pull_low = ~cur.shreg[6];
            end
          end
        end
        ST_TXACK:
        begin
          if (ev.clk_rise)
          begin
            if (ev.data)
              next_cur.phase = ST_IGNORE;
            else
            begin
              next_cur.reg_addr = cur.reg_addr + 1'b1;
              next_cur.read_dir = 1'b1;
              next_cur.phase = ST_ACK;
              next_cur.pull_low = 1'b0;
            end
          end
        end
        default:
        begin
          next_cur.phase = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cur <= '0;
      cur.idle <= 1'b1;
      cur.phase <= ST_IDLE;
    end
    else
      cur <= next_cur;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (int i = 0; i < 256; i++)
        regs[i] <= REG_RESET;
    end
    else if (cur.wr.strobe)
      regs[cur.wr.addr] <= cur.wr.data;
  end

  always_comb
  begin
    for (int i = 0; i < 256; i++)
      reg_image[i] = regs[i];
  end

  // Open drain: the high level comes from the pull-up only
  assign data_out = 1'b0;
  assign data_oe = cur.pull_low & selected;
  assign bus_idle = cur.idle;
  assign timeout_abort = cur.abort;
  assign reg_write = cur.wr;

endmodule

/* verilog/smbus_port_pkg.sv */
// Shared constants and types for the serial management slave port
package smbus_port_pkg;

  // Bus address and frame layout
  localparam logic [6:0] SLAVE_ADDR     = 7'h56;
  localparam logic [7:0] WRITE_ADDR_BYTE = 8'hAC;
  localparam int         BITS_PER_BYTE  = 8;
  localparam logic [3:0] ACK_SLOT       = 4'h8;
  localparam logic [7:0] REG_RESET      = 8'h00;

  // Timing
  localparam int CLK_HZ               = 25_000_000;
  localparam int BUS_FREE_TIME_NS     = 4700;
  localparam int CLOCK_HIGH_LIMIT_US  = 50;
  localparam int CLOCK_LOW_TIMEOUT_MS = 25;
  localparam int FREE_CYCLES  = (BUS_FREE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int HIGH_CYCLES  = CLOCK_HIGH_LIMIT_US * (CLK_HZ / 1_000_000);
  localparam int LOW_CYCLES   = CLOCK_LOW_TIMEOUT_MS * (CLK_HZ / 1_000);
  localparam int FILTER_LEN   = 3;
  localparam int CNT_W        = 20;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_ACK    = 3'b010,
    ST_RXBYTE = 3'b011,
    ST_TXBYTE = 3'b100,
    ST_TXACK  = 3'b101,
    ST_IGNORE = 3'b110
  } phase_t;

  // Filtered bus line levels and detected events
  typedef struct packed {
    logic bus_clock_line;
    logic data;
    logic clk_rise;
    logic clk_fall;
    logic start;
    logic stop;
  } line_events_t;

  // Register write strobe with its address and data
  typedef struct packed {
    logic       strobe;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

endpackage

/* verilog/smbus_line_filter.sv */
// Synchroniser, glitch filter and start/stop detection for the two bus lines
module smbus_line_filter
  import smbus_port_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  // Raw bus pins
  input  wire logic                        clock_in,
  input  wire logic                        data_in,
  // Filtered result
  output smbus_port_pkg::line_events_t     events
);

  typedef struct packed {
    logic [1:0]            sync_c;
    logic [1:0]            sync_d;
    logic [FILTER_LEN-1:0] hist_c;
    logic [FILTER_LEN-1:0] hist_d;
    logic                  c;
    logic                  d;
    line_events_t          ev;
  } filt_state_t;

  filt_state_t cur;
  filt_state_t next_cur;

  always_comb
  begin
    next_cur = cur;
    // First stage feeds only the second stage
    next_cur.sync_c = {cur.sync_c[0], clock_in};
    next_cur.sync_d = {cur.sync_d[0], data_in};
    next_cur.hist_c = {cur.hist_c[FILTER_LEN-2:0], cur.sync_c[1]};
    next_cur.hist_d = {cur.hist_d[FILTER_LEN-2:0], cur.sync_d[1]};
    // Level changes only when the history agrees, rejecting short spikes
    if (&cur.hist_c)
      next_cur.c = 1'b1;
    else if (~|cur.hist_c)
      next_cur.c = 1'b0;
    if (&cur.hist_d)
      next_cur.d = 1'b1;
    else if (~|cur.hist_d)
      next_cur.d = 1'b0;
    next_cur.ev.bus_clock_line = cur.c;
    next_cur.ev.data           = cur.d;
    next_cur.ev.clk_rise = next_cur.c & ~cur.c;
    next_cur.ev.clk_fall = ~next_cur.c & cur.c;
    next_cur.ev.start = cur.c & next_cur.c & cur.d & ~next_cur.d;
    next_cur.ev.stop  = cur.c & next_cur.c & ~cur.d & next_cur.d;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cur        <= '0;
      cur.sync_c <= 2'b11;
      cur.sync_d <= 2'b11;
      cur.hist_c <= '1;
      cur.hist_d <= '1;
      cur.c      <= 1'b1;
      cur.d      <= 1'b1;
      cur.ev.bus_clock_line <= 1'b1;
      cur.ev.data           <= 1'b1;
    end
    else
      cur <= next_cur;
  end

  assign events = cur.ev;

endmodule

/* tb/smbus_select_slave_port_assertions.sv */
// Pin-level checks for the select-gated slave port
module smbus_select_slave_port_assertions
  import smbus_port_pkg::*;
(
  // Clock and reset
  input wire logic                       clk_sys,
  input wire logic                       reset,
  // Inputs
  input wire logic                       port_select,
  input wire logic                       standby,
  input wire logic                       bus_clock_line,
  input wire logic                       data_in,
  // Outputs
  input wire logic                       data_out,
  input wire logic                       data_oe,
  input wire logic                       bus_idle,
  input wire logic                       timeout_abort,
  input wire smbus_port_pkg::reg_write_t reg_write,
  input wire logic [255:0][7:0]          reg_image
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  chk_out_never_high: assert property (data_out == 1'b0)
    else $error("data driven high");
  chk_oe_deselected: assert property (
    !$past(port_select, 3) && !$past(port_select, 4) |-> !data_oe)
    else $error("data pulled while deselected");
  chk_write_deselected: assert property (
    !$past(port_select, 3) && !$past(port_select, 4) |-> !reg_write.strobe)
    else $error("write while deselected");
  chk_write_stored: assert property (
    reg_write.strobe |=> reg_image[$past(reg_write.addr)] == $past(reg_write.data))
    else $error("written byte not stored");
  chk_image_cause: assert property (
    $changed(reg_image) && !$past(reset) |-> reg_write.strobe || $past(reg_write.strobe))
    else $error("register changed without write");
  chk_oe_clock_low: assert property (
    $changed(data_oe) && !$past(reset) |-> !bus_clock_line)
    else $error("data changed with clock high");
  chk_ack_width: assert property ($rose(data_oe) |-> data_oe[*8])
    else $error("pull-low too short");
  chk_idle_lines: assert property (
    $rose(bus_idle) && !$past(reset) |-> $past(data_in, 8) && $past(bus_clock_line, 8))
    else $error("idle without high lines");
  chk_abort_low: assert property (
    timeout_abort |-> !bus_clock_line && !$past(bus_clock_line, 8))
    else $error("abort with clock high");

  cover property (reg_write.strobe);
  cover property ($rose(data_oe));
  cover property ($rose(bus_idle));
endmodule

/* tb/smbus_host_model.sv */
// Host master model: bus clock, data pull-down and port select
module smbus_host_model
(
  // Clock
  input  wire logic clk_sys,
  // Bus
  input  wire logic data_wire,
  output logic      clock_line,
  output logic      pull_low,
  output logic      select
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    clock_line = 1'b1;
    pull_low = 1'b0;
    select = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic start_cond(input logic sel);
    select = sel;
    // Slave lets go of its acknowledge late, so hold the clock low past that
    wait_clk(10);
    pull_low = 1'b0;
    clock_line = 1'b1;
    wait_clk(8);
    pull_low = 1'b1;
    wait_clk(8);
    clock_line = 1'b0;
  endtask
  task automatic stop_cond();
    pull_low = 1'b1;
    wait_clk(8);
    clock_line = 1'b1;
    wait_clk(8);
    pull_low = 1'b0;
    wait_clk(4);
    select = 1'b0;
    wait_clk(118);
  endtask
  // Long low phase: the slave answers only after its line filter
  task automatic bit_io(input logic b, output logic r);
    wait_clk(2);
    pull_low = !b;
    wait_clk(12);
    clock_line = 1'b1;
    wait_clk(4);
    r = data_wire;
    clock_line = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(1'b1, ack);
  endtask
  // Read one byte and acknowledge it so the slave carries on
  task automatic read_more(output logic [7:0] rx);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, rx[i]);
    bit_io(1'b0, a);
  endtask
endmodule

/* tb/test_smbus_select_slave_port.sv */
// Self-checking bench for the select-gated slave port
module test_smbus_select_slave_port;
  timeunit 1ns;
  timeprecision 1ns;
  import smbus_port_pkg::*;
  logic              clk_sys = 1'b0;
  logic              reset = 1'b1;
  logic              standby = 1'b0;
  logic              clock_line;
  logic              pull_low;
  logic              select;
  logic              data_out;
  logic              data_oe;
  logic              bus_idle;
  logic              timeout_abort;
  reg_write_t        reg_write;
  logic [255:0][7:0] reg_image;
  int                errors = 0;
  int                check_count = 0;
  int                cycles = 0;
  // Open-drain wire with pull-up
  wire data_wire = !(data_oe === 1'b1 && data_out === 1'b0) && !pull_low;

  initial
  begin
    forever #20 clk_sys = !clk_sys;
  end

  smbus_select_slave_port dut (
    .clk_sys(clk_sys), .reset(reset), .port_select(select), .standby(standby),
    .bus_clock_line(clock_line), .data_in(data_wire), .data_out(data_out),
    .data_oe(data_oe), .bus_idle(bus_idle), .timeout_abort(timeout_abort),
    .reg_write(reg_write), .reg_image(reg_image));
  smbus_host_model host (
    .clk_sys(clk_sys), .data_wire(data_wire), .clock_line(clock_line),
    .pull_low(pull_low), .select(select));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic write_reg(input logic sel, input logic [7:0] dev, input logic [7:0] addr,
                           input logic [7:0] val, input logic ack);
    logic [7:0] rx;
    logic       a;
    host.start_cond(sel);
    host.xfer(dev, rx, a);
    check({7'h0, a}, {7'h0, ack});
    host.xfer(addr, rx, a);
    check({7'h0, a}, {7'h0, ack});
    host.xfer(val, rx, a);
    check({7'h0, a}, {7'h0, ack});
    host.stop_cond();
  endtask
  task automatic t_write_read();
    logic [7:0] rx;
    logic       a;
    standby = 1'b1;
    check(reg_image[8'h10], REG_RESET);
    write_reg(1'b1, WRITE_ADDR_BYTE, 8'h10, 8'h5A, 1'b0);
    check(reg_image[8'h10], 8'h5A);
    host.start_cond(1'b1);
    host.xfer(WRITE_ADDR_BYTE, rx, a);
    host.xfer(8'h10, rx, a);
    check({7'h0, a}, 8'h00);
    host.start_cond(1'b1);
    host.xfer({SLAVE_ADDR, 1'b1}, rx, a);
    check({7'h0, a}, 8'h00);
    host.xfer(8'hFF, rx, a);
    check(rx, 8'h5A);
    host.stop_cond();
    standby = 1'b0;
    $display("test write_read done");
  endtask
  task automatic t_other_addr();
    write_reg(1'b1, {SLAVE_ADDR ^ 7'h01, 1'b0}, 8'h11, 8'h33, 1'b1);
    check(reg_image[8'h11], 8'h00);
    $display("test other_addr done");
  endtask
  task automatic t_deselect();
    write_reg(1'b0, WRITE_ADDR_BYTE, 8'h12, 8'h77, 1'b1);
    check(reg_image[8'h12], 8'h00);
    $display("test deselect done");
  endtask
  task automatic t_burst();
    logic [7:0] rx;
    logic       a;
    host.start_cond(1'b1);
    host.xfer(WRITE_ADDR_BYTE, rx, a);
    check({7'h0, bus_idle}, 8'h00);
    host.xfer(8'h20, rx, a);
    host.xfer(8'hC3, rx, a);
    host.xfer(8'h3C, rx, a);
    check({7'h0, a}, 8'h00);
    host.stop_cond();
    check(reg_image[8'h20], 8'hC3);
    check(reg_image[8'h21], 8'h3C);
    host.start_cond(1'b1);
    host.xfer(WRITE_ADDR_BYTE, rx, a);
    host.xfer(8'h20, rx, a);
    host.start_cond(1'b1);
    host.xfer({SLAVE_ADDR, 1'b1}, rx, a);
    host.read_more(rx);
    check(rx, 8'hC3);
    host.xfer(8'hFF, rx, a);
    check(rx, 8'h3C);
    host.stop_cond();
    $display("test burst done");
  endtask
  task automatic t_idle();
    host.wait_clk(20);
    check({7'h0, bus_idle}, 8'h01);
    check({7'h0, timeout_abort}, 8'h00);
    $display("test idle done");
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      errors++;
      conclude();
    end
  end

  initial
  begin
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    host.wait_clk(4);
    t_write_read();
    t_other_addr();
    t_deselect();
    t_burst();
    t_idle();
    conclude();
  end
endmodule

bind smbus_select_slave_port smbus_select_slave_port_assertions chk (
  .clk_sys(clk_sys), .reset(reset), .port_select(port_select), .standby(standby),
  .bus_clock_line(bus_clock_line), .data_in(data_in), .data_out(data_out),
  .data_oe(data_oe), .bus_idle(bus_idle), .timeout_abort(timeout_abort),
  .reg_write(reg_write), .reg_image(reg_image));
